// file: verilog/fid_map_pkg.sv
// constants shared by the function-number mapper and its requester-id core
// assumes a single core clock; no software-visible registers exist
package fid_map_pkg;

  // ----------------------------------------------------------------
  // capacity and widths
  // ----------------------------------------------------------------
  localparam int MAX_PF = 8;
  localparam int MAX_VF_TOTAL = 2048;
  localparam int PF_W = 3;
  localparam int VF_W = 11;
  localparam int FN_W = 12;
  localparam int BUS_W = 8;
  localparam int RID_W = 16;

  // ----------------------------------------------------------------
  // build-time defaults and fixed routing constants
  // ----------------------------------------------------------------
  localparam int DEF_NUM_PF = 4;
  localparam int DEF_DATA_W = 64;
  localparam logic [FN_W-1:0] VF_STRIDE = 12'h001;
  // requester id lives in header dword 1, bits 31:16, of the first beat
  localparam int RID_LSB = 48;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PF_W-1:0] PF_RST = 3'h0;
  localparam logic [VF_W-1:0] VF_RST = 11'h000;
  localparam logic [RID_W-1:0] RID_RST = 16'h0000;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  typedef int vf_count_t [MAX_PF];

  localparam vf_count_t DEF_VF_COUNT = '{4, 4, 4, 4, 0, 0, 0, 0};

  // first virtual-function slot (relative to end of pf block) for pf p
  function automatic int vf_base_of(vf_count_t c, int p);
    int s;
    s = 0;
    for (int i = 0; i < MAX_PF; i++)
    begin
      if (i < p)
      begin
        s += c[i];
      end
    end
    return s;
  endfunction : vf_base_of

endpackage : fid_map_pkg

// file: verilog/fid_map_if.sv
// carrier between the packet front end and the requester-id core
// assumes both ends run on core_clk
`timescale 1ns/100ps
interface fid_map_if;
  import fid_map_pkg::*;
  logic [PF_W-1:0] pf_index;
  logic [VF_W-1:0] vf_index;
  logic is_vf;
  logic [BUS_W-1:0] bus_number;
  logic [RID_W-1:0] requester_id;
  logic [FN_W-1:0] function_number;
  logic index_error;

  modport front (output pf_index, vf_index, is_vf, bus_number,
                 input requester_id, function_number, index_error);
  modport core (input pf_index, vf_index, is_vf, bus_number,
                output requester_id, function_number, index_error);
endinterface : fid_map_if

// file: verilog/rid_core.sv
// static function address map and requester-id arithmetic
// assumes indices are stable in the cycle they are used; purely combinational result
`timescale 1ns/100ps
module rid_core
  import fid_map_pkg::*;
#(
  parameter int NUM_PF = DEF_NUM_PF,
  parameter vf_count_t VF_COUNT = DEF_VF_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst_core_n,
  fid_map_if.core map
);

  // ----------------------------------------------------------------
  // build-time offset table, one entry per pf
  // ----------------------------------------------------------------
  localparam int TOTAL_VF = vf_base_of(VF_COUNT, MAX_PF);

  logic [FN_W-1:0] vf_offset [MAX_PF];
  logic [VF_W:0] vf_limit [MAX_PF];

  // offsets are elaboration constants; no write path exists
  for (genvar g = 0; g < MAX_PF; g++)
  begin : g_map
    assign vf_offset[g] = FN_W'(NUM_PF + vf_base_of(VF_COUNT, g) - g);
    assign vf_limit[g] = (g < NUM_PF) ? (VF_W+1)'(VF_COUNT[g]) : '0;
  end

  // ----------------------------------------------------------------
  // function number and requester id
  // ----------------------------------------------------------------
  logic [FN_W-1:0] pf_fn;
  logic [FN_W-1:0] vf_fn;
  logic pf_bad;
  logic vf_bad;

  always_comb
  begin
    pf_fn = FN_W'(map.pf_index);
    // offset plus stride times index, relative to the parent pf
    vf_fn = pf_fn + vf_offset[map.pf_index] + FN_W'(VF_STRIDE * map.vf_index);
    pf_bad = (32'(map.pf_index) >= NUM_PF);
    vf_bad = map.is_vf && ({1'b0, map.vf_index} >= vf_limit[map.pf_index]);
    map.function_number = map.is_vf ? vf_fn : pf_fn;
    // ari: function numbers above 255 carry into the bus field
    map.requester_id = {map.bus_number, 8'h00} + RID_W'(map.function_number);
    map.index_error = pf_bad || vf_bad;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_VF_TOTAL: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    TOTAL_VF <= MAX_VF_TOTAL && NUM_PF <= MAX_PF && NUM_PF >= 1)
    else $error("virtual function total or pf count out of range");

  AST_PF_ADDR: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !map.is_vf |-> map.function_number == 12'(map.pf_index))
    else $error("pf function number not equal to pf index");

  AST_VF_AFTER_PF: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    map.is_vf && !map.index_error |-> map.function_number >= 12'(NUM_PF)
      && map.function_number < 12'(NUM_PF + TOTAL_VF))
    else $error("vf function number outside vf block");

  AST_RUN_START: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    map.is_vf && map.vf_index == 11'h000 && map.pf_index == 3'h0 && !map.index_error
      |-> map.function_number == 12'(NUM_PF))
    else $error("first vf of pf 0 not directly after the pfs");

  AST_OFFSET_CONST: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    map.pf_index == $past(map.pf_index) |-> $stable(vf_offset[map.pf_index]))
    else $error("vf offset changed at run time");

endmodule : rid_core

// file: verilog/sriov_function_id_mapper.sv
// transmit-side requester-id insertion for an sr-iov bridge
// assumes index, bus number and beat inputs come from logic on core_clk
`timescale 1ns/100ps

// What this block does
// - supports up to eight pfs and 2048 vfs in total.
// - function address map fixed at build time from pf and vf counts.
// - vf stride and offset are build constants, never changed at run time.
// - pfs take consecutive function numbers from zero.
// - vfs follow all pfs, one contiguous run per pf, in pf order.
// - with four pfs, pf0 vfs start at 4, pf1 vfs at N0+4.
// - indices captured when first-beat and beat-valid are both high.
// - requester id from indices, bus number, offset and stride, put in header.
module sriov_function_id_mapper
  import fid_map_pkg::*;
#(
  parameter int DATA_W = DEF_DATA_W,
  parameter int NUM_PF = DEF_NUM_PF,
  parameter vf_count_t VF_COUNT = DEF_VF_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tx_beat_valid,
  input wire logic tx_packet_first_beat,
  input wire logic tx_packet_last_beat,
  input wire logic [DATA_W-1:0] tx_beat_data,
  input wire logic [PF_W-1:0] requester_pf_index,
  input wire logic [VF_W-1:0] requester_vf_index,
  input wire logic requester_is_vf,
  input wire logic [BUS_W-1:0] captured_bus_number,
  output logic out_beat_valid,
  output logic out_packet_first_beat,
  output logic out_packet_last_beat,
  output logic [DATA_W-1:0] out_beat_data,
  output logic [RID_W-1:0] out_requester_id,
  output logic out_index_error
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync_reg <= RST_SYNC_RST;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_core_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // index capture
  // ----------------------------------------------------------------
  logic start;
  logic [PF_W-1:0] pf_hold_reg;
  logic [PF_W-1:0] pf_hold_next;
  logic [VF_W-1:0] vf_hold_reg;
  logic [VF_W-1:0] vf_hold_next;
  logic is_vf_hold_reg;
  logic is_vf_hold_next;
  logic [BUS_W-1:0] bus_hold_reg;
  logic [BUS_W-1:0] bus_hold_next;

  fid_map_if map ();

  assign start = tx_packet_first_beat && tx_beat_valid;

  always_comb
  begin
    pf_hold_next = pf_hold_reg;
    vf_hold_next = vf_hold_reg;
    is_vf_hold_next = is_vf_hold_reg;
    bus_hold_next = bus_hold_reg;
    // indices move only on an accepted first beat
    if (start)
    begin
      pf_hold_next = requester_pf_index;
      vf_hold_next = requester_vf_index;
      is_vf_hold_next = requester_is_vf;
      bus_hold_next = captured_bus_number;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      pf_hold_reg <= PF_RST;
      vf_hold_reg <= VF_RST;
      is_vf_hold_reg <= 1'b0;
      bus_hold_reg <= '0;
    end
    else
    begin
      pf_hold_reg <= pf_hold_next;
      vf_hold_reg <= vf_hold_next;
      is_vf_hold_reg <= is_vf_hold_next;
      bus_hold_reg <= bus_hold_next;
    end
  end

  // the core sees the live values on the first beat so the id is ready without a bubble
  always_comb
  begin
    map.pf_index = pf_hold_next;
    map.vf_index = vf_hold_next;
    map.is_vf = is_vf_hold_next;
    map.bus_number = bus_hold_next;
  end

  rid_core #(
    .NUM_PF(NUM_PF),
    .VF_COUNT(VF_COUNT)
  ) u_rid_core (
    .core_clk(core_clk),
    .rst_core_n(rst_core_n),
    .map(map)
  );

  // ----------------------------------------------------------------
  // output stage with header rewrite
  // ----------------------------------------------------------------
  logic valid_next;
  logic first_next;
  logic last_next;
  logic [DATA_W-1:0] data_next;
  logic [RID_W-1:0] rid_next;
  logic err_next;

  always_comb
  begin
    valid_next = tx_beat_valid;
    first_next = tx_packet_first_beat && tx_beat_valid;
    last_next = tx_packet_last_beat && tx_beat_valid;
    data_next = tx_beat_data;
    rid_next = out_requester_id;
    err_next = out_index_error;
    if (start)
    begin
      data_next[RID_LSB +: RID_W] = map.requester_id;
      rid_next = map.requester_id;
      // a bad index still goes out; the flag lets the application drop it
      err_next = map.index_error;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      out_beat_valid <= 1'b0;
      out_packet_first_beat <= 1'b0;
      out_packet_last_beat <= 1'b0;
      out_beat_data <= '0;
      out_requester_id <= RID_RST;
      out_index_error <= 1'b0;
    end
    else
    begin
      out_beat_valid <= valid_next;
      out_packet_first_beat <= first_next;
      out_packet_last_beat <= last_next;
      out_beat_data <= data_next;
      out_requester_id <= rid_next;
      out_index_error <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_first_taken;
    tx_packet_first_beat && tx_beat_valid;
  endsequence

  sequence s_rid_in_header;
    out_packet_first_beat && out_beat_data[RID_LSB +: RID_W] == out_requester_id;
  endsequence

  AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    s_first_taken |=> pf_hold_reg == $past(requester_pf_index) && vf_hold_reg == $past(requester_vf_index))
    else $error("indices not captured on first beat");

  AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !(tx_packet_first_beat && tx_beat_valid) |=> $stable(pf_hold_reg) && $stable(vf_hold_reg)
      && $stable(out_requester_id))
    else $error("captured indices changed mid packet");

  AST_RID_INSERT: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    s_first_taken ##1 1'b1 |-> s_rid_in_header)
    else $error("requester id not placed in first beat header");

  AST_RID_PF: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    (s_first_taken and !requester_is_vf) |=>
      out_requester_id == {$past(captured_bus_number), 8'h00} + 16'($past(requester_pf_index)))
    else $error("pf requester id wrong");

  AST_PASS: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    tx_beat_valid && !tx_packet_first_beat |=> out_beat_valid && out_beat_data == $past(tx_beat_data))
    else $error("non-first beat altered in passing");

  // markers pass with exactly one cycle of latency, never stalled
  AST_BEAT_LATENCY: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    1'b1 |=> out_beat_valid == $past(tx_beat_valid)
      && out_packet_first_beat == ($past(tx_packet_first_beat) && $past(tx_beat_valid))
      && out_packet_last_beat == ($past(tx_packet_last_beat) && $past(tx_beat_valid)))
    else $error("beat markers not passed with one cycle latency");

  AST_KIND_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    s_first_taken |=> is_vf_hold_reg == $past(requester_is_vf) && bus_hold_reg == $past(captured_bus_number))
    else $error("requester kind or bus number not captured on first beat");

  AST_ERR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !(tx_packet_first_beat && tx_beat_valid) |=> $stable(out_index_error) && $stable(is_vf_hold_reg)
      && $stable(bus_hold_reg))
    else $error("index error flag or captured kind changed mid packet");

endmodule : sriov_function_id_mapper

// file: sim/tx_app_model.sv
// application-side model that sources transmit packets into the mapper
// assumes the bench calls its tasks; beats change at the falling edge of core_clk
`timescale 1ns/100ps
module tx_app_model
  import fid_map_pkg::*;
(
  input wire logic core_clk,
  output logic tx_beat_valid,
  output logic tx_packet_first_beat,
  output logic tx_packet_last_beat,
  output logic [DEF_DATA_W-1:0] tx_beat_data,
  output logic [PF_W-1:0] requester_pf_index,
  output logic [VF_W-1:0] requester_vf_index,
  output logic requester_is_vf,
  output logic [BUS_W-1:0] captured_bus_number
);
  initial
  begin
    tx_beat_valid = 1'b0;
    tx_packet_first_beat = 1'b0;
    tx_packet_last_beat = 1'b0;
    tx_beat_data = 64'h0;
    requester_pf_index = 3'h0;
    requester_vf_index = 11'h000;
    requester_is_vf = 1'b0;
    captured_bus_number = 8'h00;
  end

  // index lines are only meaningful on a first beat; keep them moving elsewhere
  task automatic scramble();
    requester_pf_index = 3'($urandom);
    requester_vf_index = 11'($urandom);
    requester_is_vf = 1'($urandom);
    captured_bus_number = 8'($urandom);
  endtask : scramble

  task automatic idle(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      tx_beat_valid = 1'b0;
      tx_packet_first_beat = 1'($urandom);
      tx_packet_last_beat = 1'($urandom);
      tx_beat_data = ~tx_beat_data;
      scramble();
    end
  endtask : idle

  task automatic send(input logic [PF_W-1:0] pf, input logic [VF_W-1:0] vf, input logic is_vf,
                      input logic [BUS_W-1:0] bus, input int beats);
    for (int b = 0; b < beats; b++)
    begin
      @(negedge core_clk);
      tx_beat_valid = 1'b1;
      tx_packet_first_beat = (b == 0);
      tx_packet_last_beat = (b == beats - 1);
      tx_beat_data = {$urandom, $urandom};
      if (b == 0)
      begin
        requester_pf_index = pf;
        requester_vf_index = vf;
        requester_is_vf = is_vf;
        captured_bus_number = bus;
      end
      else
      begin
        scramble();
      end
    end
  endtask : send
endmodule : tx_app_model

// file: sim/tb_top.sv
// self-checking bench for the requester-id mapper
// assumes default build of four pfs with four vfs each and a 64-bit beat
`timescale 1ns/100ps
module tb_top
  import fid_map_pkg::*;
;
  localparam int NPF = 4;
  localparam int NVF = 4;
  logic core_clk;
  logic rst_n;
  logic chk_on;
  logic tx_beat_valid, tx_packet_first_beat, tx_packet_last_beat, requester_is_vf;
  logic [63:0] tx_beat_data, out_beat_data, e_data;
  logic [PF_W-1:0] requester_pf_index;
  logic [VF_W-1:0] requester_vf_index;
  logic [BUS_W-1:0] captured_bus_number;
  logic out_beat_valid, out_packet_first_beat, out_packet_last_beat, out_index_error;
  logic [RID_W-1:0] out_requester_id, e_id;
  logic e_valid, e_first, e_last, e_err;
  int mismatches, n_tests;

  tx_app_model i_app (.core_clk(core_clk), .tx_beat_valid(tx_beat_valid),
    .tx_packet_first_beat(tx_packet_first_beat), .tx_packet_last_beat(tx_packet_last_beat),
    .tx_beat_data(tx_beat_data), .requester_pf_index(requester_pf_index),
    .requester_vf_index(requester_vf_index), .requester_is_vf(requester_is_vf),
    .captured_bus_number(captured_bus_number));

  sriov_function_id_mapper #(.DATA_W(64), .NUM_PF(NPF), .VF_COUNT('{NVF, NVF, NVF, NVF, 0, 0, 0, 0})) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .tx_beat_valid(tx_beat_valid),
    .tx_packet_first_beat(tx_packet_first_beat), .tx_packet_last_beat(tx_packet_last_beat),
    .tx_beat_data(tx_beat_data), .requester_pf_index(requester_pf_index),
    .requester_vf_index(requester_vf_index), .requester_is_vf(requester_is_vf),
    .captured_bus_number(captured_bus_number), .out_beat_valid(out_beat_valid),
    .out_packet_first_beat(out_packet_first_beat), .out_packet_last_beat(out_packet_last_beat),
    .out_beat_data(out_beat_data), .out_requester_id(out_requester_id), .out_index_error(out_index_error));

  // -----------------------------------------------------------
  // expectation
  // -----------------------------------------------------------
  // pfs first, then one run of vfs per pf in pf order
  function automatic logic [RID_W-1:0] exp_id(logic [PF_W-1:0] pf, logic [VF_W-1:0] vf, logic is_vf,
                                             logic [BUS_W-1:0] bus);
    logic [FN_W-1:0] fn;
    fn = is_vf ? FN_W'(NPF + ((pf < NPF) ? int'(pf) * NVF : NPF * NVF) + int'(vf)) : FN_W'(pf);
    return {bus, 8'h00} + RID_W'(fn);
  endfunction : exp_id

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {e_valid, e_first, e_last, e_err, e_id, e_data} <= '0;
    end
    else
    begin
      e_valid <= tx_beat_valid;
      e_first <= tx_beat_valid && tx_packet_first_beat;
      e_last <= tx_beat_valid && tx_packet_last_beat;
      e_data <= tx_beat_data;
      if (tx_beat_valid && tx_packet_first_beat)
      begin
        e_id <= exp_id(requester_pf_index, requester_vf_index, requester_is_vf, captured_bus_number);
        e_err <= (requester_pf_index >= NPF) || (requester_is_vf && requester_vf_index >= NVF);
        e_data <= {exp_id(requester_pf_index, requester_vf_index, requester_is_vf, captured_bus_number),
                   tx_beat_data[47:0]};
      end
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(negedge core_clk)
  begin
    if (chk_on)
    begin
      check(64'(out_beat_valid), 64'(e_valid));
      check(64'(out_packet_first_beat), 64'(e_first));
      check(64'(out_packet_last_beat), 64'(e_last));
      check(64'(out_requester_id), 64'(e_id));
      check(64'(out_index_error), 64'(e_err));
      if (e_valid)
      begin
        check(out_beat_data, e_data);
      end
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // -----------------------------------------------------------
  // stimulus
  // -----------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    #1000000;
    mismatches++;
    conclude();
  end

  initial
  begin
    mismatches = 0;
    n_tests = 0;
    chk_on = 1'b0;
    rst_n = 1'b0;
    void'($urandom(32'hC5223A97));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk_on = 1'b1;
    i_app.send(3'h1, 11'h002, 1'b1, 8'h05, 2);
    i_app.idle(2);
    $display("test walk done");
    for (int p = 0; p < 8; p++)
      i_app.send(3'(p), 11'(p), 1'b0, 8'(p + 8'hF0), 1);
    $display("test pf map done");
    for (int p = 0; p < NPF; p++)
      for (int v = 0; v < NVF; v += NVF - 1)
        i_app.send(3'(p), 11'(v), 1'b1, 8'hFF, 1);
    $display("test vf runs done");
    i_app.send(3'h4, 11'h000, 1'b1, 8'h11, 2);
    i_app.send(3'h0, 11'h004, 1'b1, 8'h22, 1);
    i_app.send(3'h3, 11'h7FF, 1'b1, 8'h33, 3);
    i_app.send(3'h2, 11'h001, 1'b1, 8'h44, 6);
    i_app.idle(1);
    $display("test range and hold done");
    for (int n = 0; n < 60; n++)
    begin
      i_app.send(3'($urandom_range(5)), 11'($urandom_range(5)), 1'($urandom), 8'($urandom),
                 int'($urandom_range(1, 4)));
      i_app.idle(int'($urandom_range(2)));
    end
    i_app.idle(2);
    $display("test random done");
    conclude();
  end
endmodule : tb_top
